// [shared/txin_defines.vh]
/*
  Constants for the transmit parallel input stage: codes, offsets, field
  positions, reset values and counts. Assumes inclusion by bare name.
*/
// What this block does
// - baud clock is reference times 10, or times 20 with double rate.
// - each character time carries 8 data bits, data/special select, word-sync request.
// - data/special select marks the character as data or control.
// - word-sync request starts a 16-character alignment sequence.
// - timing select 000 reference, 10X byte clock, 11X data eye, rest reserved.
// - chip init low recenters the skew buffer.
// - skew error goes high when the buffer drops or repeats a character.
// - skew error never raised in reference-clock capture mode.
// - skew error output timing follows the receive output timing select.
// - internal capture tick at character rate, locked to the selected source.
// - double rate with reference timing captures at rising edges and midway.
// - character rate lies between 98 and 136 MHz.
// - data-eye capture at quarter and three-quarter points between byte-clock rises.
// - after word sync is taken, inputs are ignored for fifteen character times.
`ifndef TXIN_DEFINES_VH
`define TXIN_DEFINES_VH

`define CLK_SYS_NS      20
`define CHAR_MHZ_MIN    98
`define CHAR_MHZ_MAX    136

// internal capture modes
`define MODE_REF        2'h0
`define MODE_TBC        2'h1
`define MODE_EYE        2'h2
`define MODE_RSV        2'h3

// baud multipliers
`define BAUD_X10        5'h0A
`define BAUD_X20        5'h14

// word sync sequence
`define WS_LAST         4'hF

// skew buffer
`define SKEW_AW         2
`define SKEW_DEPTH      3'h4
`define SKEW_CENTER     3'h2
`define SKEW_DW         10

// phase points in quarters of a measured period
`define PH_QTR          2'h1
`define PH_HALF         2'h2
`define PH_3QTR         2'h3
`define PER_MAX         8'hFF

// register offsets
`define REG_STATUS      2'h0
`define REG_INT_CLR     2'h1
`define REG_INT_EN      2'h2
`define REG_STATE       2'h3

// status and enable bit positions
`define ST_SKEW         0
`define ST_WSYNC        1
`define ST_RSV          2
`define INT_EN_RST      3'h0

`endif

// [core/sync2.v]
/*
  Two-flop synchroniser for a group of independent levels.
  Assumes each bit is a slow level or is re-sampled by the caller.
*/
`timescale 1ns/10ps
module sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  // first stage is read only by the second
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [core/skew_mem.v]
/*
  Small skew buffer memory, one write and one registered read port.
  Assumes the caller owns the pointers and the full/empty decisions.
*/
`timescale 1ns/10ps
`include "txin_defines.vh"
module skew_mem (
  // clock and reset
  input  wire                    clk_sys,
  input  wire                    rst_n,
  // write port
  input  wire                    wr_en,
  input  wire [`SKEW_AW-1:0]     wr_addr,
  input  wire [`SKEW_DW-1:0]     wr_data,
  // read port
  input  wire                    rd_en,
  input  wire [`SKEW_AW-1:0]     rd_addr,
  output reg  [`SKEW_DW-1:0]     rd_data
);
  reg [`SKEW_DW-1:0] mem [0:(1<<`SKEW_AW)-1];
  integer i;

  // cleared at reset so stale slots never read as unknown
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      for (i = 0; i < (1<<`SKEW_AW); i = i + 1)
        mem[i] <= {`SKEW_DW{1'b0}};
      rd_data <= {`SKEW_DW{1'b0}};
    end else begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      if (rd_en)
        rd_data <= mem[rd_addr];
    end
  end
endmodule

// [core/tx_input_stage.v]
/*
  Transmit parallel input stage: captures characters on the reference,
  on the byte clock or in the byte-clock data eye, absorbs drift in a
  skew buffer, runs the word sync sequence and reports skew overflow.
  Assumes all pins are asynchronous to clk_sys and far slower than it.
*/
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`include "txin_defines.vh"
module tx_input_stage (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // link clocks and chip init
  input  wire       ref_timing_clk,
  input  wire       tx_byte_clk,
  input  wire       chip_init_low,
  // transmit character pins
  input  wire [7:0] tx_data,
  input  wire       tx_ctrl_sel,
  input  wire       word_sync_req,
  // static configuration pins
  input  wire [2:0] tx_timing_sel,
  input  wire       dual_rate_sel,
  input  wire [1:0] rx_out_timing_sel,
  // register port
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // character output toward the encoder
  output reg        cap_tick,
  output reg        char_valid,
  output reg  [7:0] char_data,
  output reg        char_special,
  output reg        char_sync,
  output reg  [3:0] sync_index,
  // status
  output reg  [4:0] baud_mult,
  output reg        skew_overflow_err,
  output reg        mode_reserved,
  output reg        irq
);
  localparam ST_DATA = 1'b0;
  localparam ST_SYNC = 1'b1;

  // timing select decode
  function [1:0] mode_of;
    input [2:0] sel;
    begin
      if (sel == 3'h0)
        mode_of = `MODE_REF;
      else if (sel[2:1] == 2'h2)
        mode_of = `MODE_TBC;
      else if (sel[2:1] == 2'h3)
        mode_of = `MODE_EYE;
      else
        mode_of = `MODE_RSV;
    end
  endfunction

  // point at q quarters of a measured period
  function [7:0] phase_pt;
    input [7:0] per;
    input [1:0] q;
    reg   [9:0] p;
    begin
      p        = {2'h0, per} * {8'h00, q};
      phase_pt = p[9:2];
    end
  endfunction

  wire [9:0] pin_q;
  wire [8:0] cfg_q;

  sync2 #(.W(10)) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({word_sync_req, tx_ctrl_sel, tx_data}),
    .q       (pin_q)
  );

  sync2 #(.W(9)) u_cfg_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({ref_timing_clk, tx_byte_clk, chip_init_low, dual_rate_sel,
               tx_timing_sel, rx_out_timing_sel}),
    .q       (cfg_q)
  );

  wire       ref_s   = cfg_q[8];
  wire       tbc_s   = cfg_q[7];
  wire       recen   = ~cfg_q[6];
  wire       dual_s  = cfg_q[5];
  wire [1:0] mode    = mode_of(cfg_q[4:2]);
  wire [1:0] rsel_s  = cfg_q[1:0];
  wire       run     = (mode == `MODE_TBC) || (mode == `MODE_EYE);

  reg        ref_d_r;
  reg        tbc_d_r;
  reg  [7:0] ref_cnt_r;
  reg  [7:0] ref_per_r;
  reg  [7:0] tbc_cnt_r;
  reg  [7:0] tbc_per_r;

  wire ref_rise = ref_s & ~ref_d_r;
  wire tbc_rise = tbc_s & ~tbc_d_r;

  // reference character ticks: rise, plus midpoint when double rate
  wire ref_mid  = dual_s && (ref_per_r != 8'h00) && !ref_rise &&
                  (ref_cnt_r == phase_pt(ref_per_r, `PH_HALF));
  wire ref_tick = ref_rise | ref_mid;

  // byte clock ticks: rise, or quarter points of the eye
  wire eye_tick = (tbc_per_r != 8'h00) && !tbc_rise &&
                  ((tbc_cnt_r == phase_pt(tbc_per_r, `PH_QTR)) ||
                   (tbc_cnt_r == phase_pt(tbc_per_r, `PH_3QTR)));
  wire tbc_tick = (mode == `MODE_TBC) ? tbc_rise :
                  (mode == `MODE_EYE) ? eye_tick : 1'b0;

  // period measurement, counted in clk_sys cycles between rising edges
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ref_d_r   <= 1'b0;
      tbc_d_r   <= 1'b0;
      ref_cnt_r <= 8'h00;
      ref_per_r <= 8'h00;
      tbc_cnt_r <= 8'h00;
      tbc_per_r <= 8'h00;
    end else begin
      ref_d_r <= ref_s;
      tbc_d_r <= tbc_s;
      if (ref_rise) begin
        ref_per_r <= ref_cnt_r + 8'h01;
        ref_cnt_r <= 8'h00;
      end else if (ref_cnt_r != `PER_MAX) begin
        ref_cnt_r <= ref_cnt_r + 8'h01;
      end
      if (tbc_rise) begin
        tbc_per_r <= tbc_cnt_r + 8'h01;
        tbc_cnt_r <= 8'h00;
      end else if (tbc_cnt_r != `PER_MAX) begin
        tbc_cnt_r <= tbc_cnt_r + 8'h01;
      end
    end
  end

  // skew buffer pointers and overflow detection
  reg  [`SKEW_AW:0]   wr_ptr_r;
  reg  [`SKEW_AW:0]   rd_ptr_r;
  reg                 rd_pend_r;
  reg                 err_pend_r;
  wire [`SKEW_AW:0]   level    = wr_ptr_r - rd_ptr_r;
  wire                full     = (level == `SKEW_DEPTH);
  wire                empty    = (level == {(`SKEW_AW+1){1'b0}});
  wire                wr_try   = run & tbc_tick;
  wire                rd_try   = run & ref_tick;
  wire                wr_go    = wr_try & ~full;
  wire [`SKEW_AW:0]   rd_at    = empty ? rd_ptr_r - 3'h1 : rd_ptr_r;
  wire                err_evt  = (wr_try & full) | (rd_try & empty);
  wire [`SKEW_DW-1:0] mem_q;

  skew_mem u_skew_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_go),
    .wr_addr (wr_ptr_r[`SKEW_AW-1:0]),
    .wr_data (pin_q),
    .rd_en   (rd_try),
    .rd_addr (rd_at[`SKEW_AW-1:0]),
    .rd_data (mem_q)
  );

  always @(posedge clk_sys) begin
    if (!rst_n || recen || !run) begin
      wr_ptr_r   <= `SKEW_CENTER;
      rd_ptr_r   <= {(`SKEW_AW+1){1'b0}};
      rd_pend_r  <= 1'b0;
      err_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_try;
      if (wr_go)
        wr_ptr_r <= wr_ptr_r + 3'h1;
      if (rd_try && !empty)
        rd_ptr_r <= rd_ptr_r + 3'h1;
      if (err_evt)
        err_pend_r <= 1'b1;
    end
  end

  // character slot: direct on reference ticks, else from the buffer
  wire       slot_stb = ((mode == `MODE_REF) & ref_tick) | rd_pend_r;
  wire [9:0] slot_chr = rd_pend_r ? mem_q : pin_q;

  // word sync sequencer
  reg        ws_st_r;
  reg  [3:0] ws_cnt_r;
  wire       ws_start = slot_stb && (ws_st_r == ST_DATA) && slot_chr[9];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ws_st_r      <= ST_DATA;
      ws_cnt_r     <= 4'h0;
      char_valid   <= 1'b0;
      char_data    <= 8'h00;
      char_special <= 1'b0;
      char_sync    <= 1'b0;
      sync_index   <= 4'h0;
    end else begin
      char_valid <= slot_stb;
      if (slot_stb) begin
        case (ws_st_r)
          ST_DATA: begin
            if (slot_chr[9]) begin
              ws_st_r      <= ST_SYNC;
              ws_cnt_r     <= 4'h1;
              char_sync    <= 1'b1;
              sync_index   <= 4'h0;
              char_special <= 1'b1;
              char_data    <= 8'h00;
            end else begin
              char_sync    <= 1'b0;
              sync_index   <= 4'h0;
              char_special <= slot_chr[8];
              char_data    <= slot_chr[7:0];
            end
          end
          ST_SYNC: begin
            char_sync    <= 1'b1;
            char_special <= 1'b1;
            char_data    <= 8'h00;
            sync_index   <= ws_cnt_r;
            ws_cnt_r     <= ws_cnt_r + 4'h1;
            if (ws_cnt_r == `WS_LAST)
              ws_st_r <= ST_DATA;
          end
          default: begin
            ws_st_r <= ST_DATA;
          end
        endcase
      end
    end
  end

  // status outputs, capture tick and skew error timing
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cap_tick          <= 1'b0;
      baud_mult         <= `BAUD_X10;
      skew_overflow_err <= 1'b0;
      mode_reserved     <= 1'b0;
    end else begin
      cap_tick      <= (mode == `MODE_REF) ? ref_tick : tbc_tick;
      baud_mult     <= dual_s ? `BAUD_X20 : `BAUD_X10;
      mode_reserved <= (mode == `MODE_RSV);
      if (recen || !run)
        skew_overflow_err <= 1'b0;
      else if (rsel_s == 2'h0 ? ref_tick : slot_stb)
        skew_overflow_err <= err_pend_r | err_evt;
    end
  end

  // interrupt status, enable and register port
  reg  [2:0] status_r;
  reg  [2:0] int_en_r;
  reg        rsv_d_r;
  wire       rsv_evt    = (mode == `MODE_RSV) & ~rsv_d_r;
  wire [2:0] ev         = {rsv_evt, ws_start, run & err_evt};
  wire [2:0] clr        = (reg_wr && reg_addr == `REG_INT_CLR) ?
                          reg_wdata[2:0] : 3'h0;
  wire [2:0] status_nxt = (status_r & ~clr) | ev;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      status_r  <= 3'h0;
      int_en_r  <= `INT_EN_RST;
      rsv_d_r   <= 1'b0;
      irq       <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      rsv_d_r  <= (mode == `MODE_RSV);
      status_r <= status_nxt;
      irq      <= |(status_nxt & int_en_r);
      if (reg_wr && reg_addr == `REG_INT_EN)
        int_en_r <= reg_wdata[2:0];
      if (reg_rd) begin
        case (reg_addr)
          `REG_STATUS: reg_rdata <= {5'h00, status_r};
          `REG_INT_EN: reg_rdata <= {5'h00, int_en_r};
          `REG_STATE:  reg_rdata <= {ws_st_r, level, skew_overflow_err, dual_s, mode};
          default:     reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule

// [verif/tx_input_stage_properties.sv]
/* port checker for the transmit input stage
   assumes binding to tx_input_stage and its shared defines */
`timescale 1ns/10ps
`include "txin_defines.vh"
module tx_input_stage_chk (
  // clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // pins
  input wire       chip_init_low,
  input wire [2:0] tx_timing_sel,
  input wire       dual_rate_sel,
  // outputs
  input wire       cap_tick,
  input wire       char_valid,
  input wire [7:0] char_data,
  input wire       char_special,
  input wire       char_sync,
  input wire [3:0] sync_index,
  input wire [4:0] baud_mult,
  input wire       skew_overflow_err,
  input wire       mode_reserved
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // first and second characters of a sync run
  sequence sync_head;
    char_valid && char_sync && sync_index == 4'h0;
  endsequence
  sequence sync_step;
    char_valid && char_sync && sync_index == 4'h1;
  endsequence
  baud_sel_a: assert property ($stable(dual_rate_sel)[*6] |->
    baud_mult == (dual_rate_sel ? `BAUD_X20 : `BAUD_X10))
    else $error("baud multiplier wrong");
  sync_char_a: assert property (char_valid && char_sync |->
    char_special && char_data == 8'h00) else $error("sync character malformed");
  sync_next_a: assert property (sync_head |-> ##[1:40] sync_step)
    else $error("sync run did not advance");
  valid_pulse_a: assert property (char_valid |=> !char_valid)
    else $error("character strobe too long");
  tick_pulse_a: assert property (cap_tick |=> !cap_tick)
    else $error("capture tick too long");
  ref_no_err_a: assert property ((tx_timing_sel == 3'h0)[*8] |->
    !skew_overflow_err) else $error("skew error in reference mode");
  init_clear_a: assert property ((!chip_init_low)[*6] |->
    !skew_overflow_err) else $error("skew error survived recentering");
  rsv_flag_a: assert property (
    (tx_timing_sel == 3'h1 || tx_timing_sel[2:1] == 2'h1)[*6] |-> mode_reserved)
    else $error("reserved code not flagged");
  rsv_quiet_a: assert property (mode_reserved[*4] |-> !char_valid && !cap_tick)
    else $error("activity in reserved mode");
endmodule

bind tx_input_stage tx_input_stage_chk chk_u (
  .clk_sys, .rst_n, .chip_init_low, .tx_timing_sel, .dual_rate_sel,
  .cap_tick, .char_valid, .char_data, .char_special, .char_sync,
  .sync_index, .baud_mult, .skew_overflow_err, .mode_reserved
);

// [verif/host_char_model.sv]
/* host model: launches counting characters away from the capture point
   assumes the bench makes both link clocks */
`timescale 1ns/10ps
module host_char_model (
  // link clocks
  input wire       ref_timing_clk,
  input wire       tx_byte_clk,
  // launch choice: 0 reference, 1 byte clock, 2 data eye
  input wire [1:0] launch_sel,
  input wire       sync_want,
  // character pins
  output reg [7:0] tx_data,
  output reg       tx_ctrl_sel,
  output reg       word_sync_req
);
  initial begin
    tx_data = 8'h00;
    tx_ctrl_sel = 1'b0;
    word_sync_req = 1'b0;
  end
  // next character; select mirrors the new low data bit
  task launch;
    begin
      tx_data <= tx_data + 8'h01;
      tx_ctrl_sel <= ~tx_data[0];
      word_sync_req <= sync_want;
    end
  endtask
  // reference capture: change on the falling edge
  always @(negedge ref_timing_clk) begin
    if (launch_sel == 2'h0) launch;
  end
  // byte clock capture: change on the falling edge
  always @(negedge tx_byte_clk) begin
    if (launch_sel != 2'h0) launch;
  end
  // data eye: byte clock toggles once per character
  always @(posedge tx_byte_clk) begin
    if (launch_sel == 2'h2) launch;
  end
endmodule

// [verif/serdes_tx_input_skew_buffer_bench.sv]
/* bench for the transmit input stage: mode table, word sync, interrupts, drift
   assumes the host model and the port checker are compiled first */
`timescale 1ns/10ps
module serdes_tx_input_skew_buffer_bench;
  typedef struct packed {
    logic [2:0] sel; logic dual; logic [1:0] launch;
    logic [3:0] ticks; logic [4:0] baud; logic rsv; logic chk;
  } row_t;
  // stimulus and observed signals
  reg        clk_sys = 1'b0;
  reg        rst_n = 1'b0;
  reg        ref_timing_clk = 1'b0;
  reg        tx_byte_clk = 1'b0;
  reg        chip_init_low = 1'b1;
  reg  [2:0] tx_timing_sel = 3'h0;
  reg        dual_rate_sel = 1'b0;
  reg  [1:0] rx_out_timing_sel = 2'h0;
  reg  [1:0] reg_addr = 2'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [1:0] launch_sel = 2'h0;
  reg        sync_want = 1'b0;
  wire [7:0] tx_data, reg_rdata, char_data;
  wire       tx_ctrl_sel, word_sync_req, cap_tick, char_valid, char_special;
  wire       char_sync, skew_overflow_err, mode_reserved, irq;
  wire [3:0] sync_index;
  wire [4:0] baud_mult;
  real       tbc_half = 80.0;
  int        num_errors = 0;
  int        total_checks = 0;
  int        i, n, ticks;
  reg  [7:0] rd, prev;
  reg        have;
  row_t      rows [5];
  row_t      r;
  // system clock, reference, and byte clock of free phase
  always #10 clk_sys = ~clk_sys;
  always #80 ref_timing_clk = ~ref_timing_clk;
  initial begin
    #33;
    forever #(tbc_half) tx_byte_clk = ~tx_byte_clk;
  end
  tx_input_stage dut_u (
    .clk_sys, .rst_n, .ref_timing_clk, .tx_byte_clk, .chip_init_low,
    .tx_data, .tx_ctrl_sel, .word_sync_req, .tx_timing_sel, .dual_rate_sel,
    .rx_out_timing_sel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cap_tick, .char_valid, .char_data, .char_special, .char_sync,
    .sync_index, .baud_mult, .skew_overflow_err, .mode_reserved, .irq
  );
  host_char_model host_u (
    .ref_timing_clk, .tx_byte_clk, .launch_sel, .sync_want,
    .tx_data, .tx_ctrl_sel, .word_sync_req
  );
  // compare and count
  task check8(input string nm, input [7:0] e, input [7:0] g);
    begin
      total_checks++;
      if (g !== e) begin
        num_errors++;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // let c edges pass, then sample
  task settle(input int c);
    begin
      repeat (c) @(posedge clk_sys);
      #1;
    end
  endtask
  // register port cycles
  task reg_write(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task reg_read(input [1:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    rows[0] = '{3'h0, 1'b0, 2'h0, 4'h4, 5'h0A, 1'b0, 1'b1};
    rows[1] = '{3'h0, 1'b1, 2'h0, 4'h8, 5'h14, 1'b0, 1'b0};
    rows[2] = '{3'h4, 1'b0, 2'h1, 4'h4, 5'h0A, 1'b0, 1'b1};
    rows[3] = '{3'h6, 1'b1, 2'h2, 4'h8, 5'h14, 1'b0, 1'b1};
    rows[4] = '{3'h3, 1'b0, 2'h0, 4'h0, 5'h0A, 1'b1, 1'b0};
    settle(20);
    check8("baud_rst", 8'h0A, {3'h0, baud_mult});
    check8("err_rst", 8'h00, {7'h0, skew_overflow_err});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      r = rows[i];
      @(posedge clk_sys);
      tx_timing_sel <= r.sel;
      dual_rate_sel <= r.dual;
      launch_sel <= r.launch;
      chip_init_low <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chip_init_low <= 1'b1;
      settle(30);
      ticks = 0;
      have = 1'b0;
      repeat (32) begin
        settle(1);
        if (cap_tick === 1'b1) ticks++;
        if (char_valid === 1'b1 && r.chk) begin
          if (have) check8("char_data", prev + 8'h01, char_data);
          check8("special", {7'h0, char_data[0]}, {7'h0, char_special});
          prev = char_data;
          have = 1'b1;
        end
      end
      check8("ticks", {4'h0, r.ticks}, ticks[7:0]);
      check8("baud_mult", {3'h0, r.baud}, {3'h0, baud_mult});
      check8("reserved", {7'h0, r.rsv}, {7'h0, mode_reserved});
      check8("skew_err", 8'h00, {7'h0, skew_overflow_err});
    end
    @(posedge clk_sys);
    tx_timing_sel <= 3'h0;
    launch_sel <= 2'h0;
    sync_want <= 1'b1;
    n = 0;
    have = 1'b0;
    for (i = 0; i < 600 && !have; i++) begin
      settle(1);
      if (char_valid === 1'b1 && char_sync === 1'b1) begin
        if (n == 0) check8("sync_first", 8'h00, {4'h0, sync_index});
        check8("sync_index", n[7:0], {4'h0, sync_index});
        n++;
        sync_want <= 1'b0;
      end else if (char_valid === 1'b1 && n > 0) have = 1'b1;
    end
    check8("sync_count", 8'h10, n[7:0]);
    check8("sync_done", 8'h01, {7'h0, have});
    reg_read(2'h0, rd);
    check8("status_ws", 8'h02, rd & 8'h02);
    reg_write(2'h2, 8'h02);
    settle(3);
    check8("irq_on", 8'h01, {7'h0, irq});
    reg_read(2'h2, rd);
    check8("int_en_read", 8'h02, rd);
    reg_write(2'h1, 8'h02);
    settle(3);
    check8("irq_off", 8'h00, {7'h0, irq});
    reg_read(2'h1, rd);
    check8("clr_read", 8'h00, rd);
    @(posedge clk_sys);
    tx_timing_sel <= 3'h4;
    launch_sel <= 2'h1;
    rx_out_timing_sel <= 2'h1;
    tbc_half = 70.0;
    for (i = 0; i < 900 && skew_overflow_err !== 1'b1; i++) settle(1);
    check8("skew_err", 8'h01, {7'h0, skew_overflow_err});
    reg_read(2'h0, rd);
    check8("status_skew", 8'h01, rd & 8'h01);
    reg_read(2'h3, rd);
    check8("state_err", 8'h09, rd & 8'h0F);
    tbc_half = 80.0;
    @(posedge clk_sys);
    chip_init_low <= 1'b0;
    settle(8);
    check8("err_clear", 8'h00, {7'h0, skew_overflow_err});
    conclude;
  end
endmodule
